// ==== scal_loader.sv ====
// Purpose: power-up switch capture, output fault action and network address selection
// Assumes: all inputs synchronous to core_clk; nv_load holds the retained record at reset release
// Notes:   nv_store is a one-cycle write of the record to be retained across power cycles
module scal_loader (
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    input  wire logic [scal_pkg::SW_W-1:0] first_switch_bank,
    input  wire logic [scal_pkg::SW_W-1:0] second_switch_bank,
    input  wire logic                      hold_param_en,
    input  wire logic                      link_comm_error,
    input  wire logic                      master_idle,
    input  wire logic [scal_pkg::OUT_W-1:0] out_request,
    input  wire logic                      cmd_dhcp_enable,
    input  wire logic                      cmd_dhcp_disable,
    input  scal_pkg::scal_lease_t          lease,
    input  scal_pkg::scal_nv_t             nv_load,
    output logic [scal_pkg::OUT_W-1:0]     out_drive,
    output logic [31:0]                    ip_addr,
    output logic [31:0]                    net_mask,
    output logic                           addr_valid,
    output scal_pkg::scal_mode_t           addr_mode,
    output logic                           dhcp_request,
    output logic                           fault_active,
    output scal_pkg::scal_nv_t             nv_store
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic scal_pkg::scal_mode_t mode_of(input logic [7:0] sw);
        if (sw == scal_pkg::SW_ALL_ON) begin
            mode_of = scal_pkg::SCAL_MODE_DHCP;
        end else if (sw == scal_pkg::SW_ALL_OFF) begin
            mode_of = scal_pkg::SCAL_MODE_REMOTE;
        end else begin
            mode_of = scal_pkg::SCAL_MODE_STATIC;
        end
    endfunction

    function automatic logic [31:0] static_addr(input logic [7:0] sw);
        static_addr = {scal_pkg::STATIC_NET_HI, sw};
    endfunction

    scal_pkg::scal_state_t         state_q, state_d;
    scal_pkg::scal_mode_t          mode_q, mode_d;
    logic                          hold_sw_q, hold_sw_d;
    logic [7:0]                    sw2_q, sw2_d;
    logic                          dhcp_en_q, dhcp_en_d;
    logic                          req_q, req_d;
    logic [31:0]                   ip_q, ip_d;
    logic [31:0]                   mask_q, mask_d;
    logic                          valid_q, valid_d;
    logic [scal_pkg::OUT_W-1:0]    out_q, out_d;
    logic                          fault_q, fault_d;
    scal_pkg::scal_nv_t            nv_q, nv_d;
    logic                          run;
    logic                          fault_now;
    logic                          hold_eff;
    logic                          remote;
    logic                          take_lease;

    assign run        = (state_q == scal_pkg::SCAL_ST_RUN);
    assign fault_now  = link_comm_error | master_idle;
    assign hold_eff   = hold_sw_q & hold_param_en;
    assign remote     = (mode_q == scal_pkg::SCAL_MODE_REMOTE);
    assign take_lease = run & req_q & lease.valid;

    // ------------------------------------------------------------
    // Power-up capture and address selection
    // ------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        mode_d    = mode_q;
        hold_sw_d = hold_sw_q;
        sw2_d     = sw2_q;
        dhcp_en_d = dhcp_en_q;
        req_d     = req_q;
        ip_d      = ip_q;
        mask_d    = mask_q;
        valid_d   = valid_q;
        nv_d      = '0;
        case (state_q)
            scal_pkg::SCAL_ST_SAMPLE: begin
                // Only pass through here after a reset, so switches are read once
                state_d   = scal_pkg::SCAL_ST_RUN;
                hold_sw_d = first_switch_bank[scal_pkg::HOLD_SW_POS];
                sw2_d     = second_switch_bank;
                mode_d    = mode_of(second_switch_bank);
                case (mode_of(second_switch_bank))
                    scal_pkg::SCAL_MODE_STATIC: begin
                        ip_d    = static_addr(second_switch_bank);
                        mask_d  = scal_pkg::STATIC_MASK;
                        valid_d = 1'b1;
                    end
                    scal_pkg::SCAL_MODE_DHCP: begin
                        req_d = 1'b1;
                    end
                    scal_pkg::SCAL_MODE_REMOTE: begin
                        dhcp_en_d = nv_load.valid & nv_load.dhcp_en;
                        if (nv_load.valid && nv_load.dhcp_en) begin
                            req_d = 1'b1;
                        end else if (nv_load.valid) begin
                            ip_d    = nv_load.addr;
                            mask_d  = nv_load.mask;
                            valid_d = 1'b1;
                        end
                    end
                    default: begin
                        req_d = 1'b0;
                    end
                endcase
            end
            scal_pkg::SCAL_ST_RUN: begin
                if (take_lease) begin
                    ip_d    = lease.addr;
                    mask_d  = lease.mask;
                    valid_d = 1'b1;
                    req_d   = 1'b0;
                    // DHCP-mode leases are never written back
                    if (remote) begin
                        nv_d = '{valid: 1'b1, dhcp_en: 1'b1, addr: lease.addr,
                                 mask: lease.mask};
                    end
                end
                if (remote && cmd_dhcp_disable) begin
                    dhcp_en_d = 1'b0;
                    req_d     = 1'b0;
                    nv_d      = '{valid: valid_q, dhcp_en: 1'b0, addr: ip_q, mask: mask_q};
                end else if (remote && cmd_dhcp_enable) begin
                    dhcp_en_d = 1'b1;
                    req_d     = 1'b1;
                    nv_d      = '{valid: valid_q, dhcp_en: 1'b1, addr: ip_q, mask: mask_q};
                end
            end
            default: begin
                state_d = scal_pkg::SCAL_ST_SAMPLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Output fault action
    // ------------------------------------------------------------
    always_comb begin
        fault_d = run & fault_now;
        if (!run) begin
            out_d = scal_pkg::RST_OUT;
        end else if (!fault_now) begin
            out_d = out_request;
        end else if (hold_eff) begin
            out_d = out_q;
        end else begin
            out_d = scal_pkg::RST_OUT;
        end
    end

    // Shipped all-off switches land here as clear-on-fault and remote mode
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q   <= scal_pkg::SCAL_ST_SAMPLE;
            mode_q    <= scal_pkg::SCAL_MODE_REMOTE;
            hold_sw_q <= 1'b0;
            sw2_q     <= scal_pkg::SW_ALL_OFF;
            dhcp_en_q <= 1'b0;
            req_q     <= 1'b0;
            ip_q      <= scal_pkg::RST_ADDR;
            mask_q    <= scal_pkg::RST_ADDR;
            valid_q   <= 1'b0;
            out_q     <= scal_pkg::RST_OUT;
            fault_q   <= 1'b0;
            nv_q      <= '0;
        end else begin
            state_q   <= state_d;
            mode_q    <= mode_d;
            hold_sw_q <= hold_sw_d;
            sw2_q     <= sw2_d;
            dhcp_en_q <= dhcp_en_d;
            req_q     <= req_d;
            ip_q      <= ip_d;
            mask_q    <= mask_d;
            valid_q   <= valid_d;
            out_q     <= out_d;
            fault_q   <= fault_d;
            nv_q      <= nv_d;
        end
    end

    assign out_drive    = out_q;
    assign ip_addr      = ip_q;
    assign net_mask     = mask_q;
    assign addr_valid   = valid_q;
    assign addr_mode    = mode_q;
    assign dhcp_request = req_q;
    assign fault_active = fault_q;
    assign nv_store     = nv_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_capture_once;
        run |=> $stable(mode_q) && $stable(hold_sw_q) && $stable(sw2_q);
    endproperty
    a_capture_once: assert property (p_capture_once) else $error("switch capture changed");

    property p_fault_flag;
        run && (link_comm_error || master_idle) |=> fault_active;
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault not flagged");

    property p_clear_on_fault;
        run && fault_now && !hold_eff |=> out_drive == scal_pkg::RST_OUT;
    endproperty
    a_clear_on_fault: assert property (p_clear_on_fault) else $error("outputs not cleared");

    property p_hold_on_fault;
        run && fault_now && hold_sw_q && hold_param_en |=> $stable(out_drive);
    endproperty
    a_hold_on_fault: assert property (p_hold_on_fault) else $error("outputs not held");

    property p_param_disables;
        run && fault_now && !hold_param_en |=> out_drive == scal_pkg::RST_OUT;
    endproperty
    a_param_disables: assert property (p_param_disables) else $error("hold not disabled");

    property p_static_addr;
        run && mode_q == scal_pkg::SCAL_MODE_STATIC |->
            ip_addr == static_addr(sw2_q) && net_mask == scal_pkg::STATIC_MASK && addr_valid;
    endproperty
    a_static_addr: assert property (p_static_addr) else $error("static address wrong");

    property p_dhcp_request;
        $rose(run) && mode_q == scal_pkg::SCAL_MODE_DHCP |-> dhcp_request && !addr_valid;
    endproperty
    a_dhcp_request: assert property (p_dhcp_request) else $error("no DHCP request");

    property p_dhcp_not_kept;
        mode_q == scal_pkg::SCAL_MODE_DHCP |-> !nv_store.valid;
    endproperty
    a_dhcp_not_kept: assert property (p_dhcp_not_kept) else $error("DHCP lease stored");

    property p_remote_disable;
        run && remote && cmd_dhcp_disable |=> !dhcp_en_q && !dhcp_request && !nv_store.dhcp_en;
    endproperty
    a_remote_disable: assert property (p_remote_disable) else $error("disable ignored");

    property p_remote_powerup;
        $rose(run) && remote && dhcp_en_q |-> dhcp_request;
    endproperty
    a_remote_powerup: assert property (p_remote_powerup) else $error("no fresh request");

    property p_remote_quiet;
        run && remote && !dhcp_en_q |-> !dhcp_request;
    endproperty
    a_remote_quiet: assert property (p_remote_quiet) else $error("request while disabled");

endmodule

// ==== scal_pkg.sv ====
// Purpose: constants and carriers of the switch configuration and address loader
// Assumes: nrst is the power-on reset; a power cycle always asserts it
// Notes:   switch inputs are active high, 1 = switch ON
//
// What this block does
// - Switch positions are captured once after power-up and later changes are ignored.
// - The output fault action applies while the link reports an error or the master idles.
// - First bank switch 1 off clears all outputs on fault, on holds their last value.
// - A configuration parameter can disable the hold switch, which then reads as off.
// - Second bank value N of 1 to 254 gives static address 136.129.2.N, mask 255.255.0.0.
// - Second bank all on selects DHCP mode and the address is requested from a server.
// - An address obtained in DHCP mode is never kept across power loss.
// - Second bank all off selects remote mode, which obeys enable and disable DHCP commands.
// - Remote mode with DHCP enabled and a valid retained record requests a fresh address at every power-up.
// - Remote mode with DHCP disabled stops requesting and keeps the stored address.
// - All switches off is the shipped state: outputs cleared on fault, remote mode.
package scal_pkg;

    // ------------------------------------------------------------
    // Widths and fixed values
    // ------------------------------------------------------------
    localparam int          SW_W          = 8;
    localparam int          OUT_W         = 32;
    localparam int          HOLD_SW_POS   = 0;
    localparam logic [7:0]  SW_ALL_ON     = 8'hFF;
    localparam logic [7:0]  SW_ALL_OFF    = 8'h00;
    localparam logic [23:0] STATIC_NET_HI = 24'h888102;
    localparam logic [31:0] STATIC_MASK   = 32'hFFFF0000;
    localparam logic [31:0] RST_ADDR      = 32'h00000000;
    localparam logic [31:0] RST_OUT       = 32'h00000000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SCAL_MODE_STATIC = 2'b00,
        SCAL_MODE_DHCP   = 2'b01,
        SCAL_MODE_REMOTE = 2'b10
    } scal_mode_t;

    typedef enum logic [0:0] {
        SCAL_ST_SAMPLE = 1'b0,
        SCAL_ST_RUN    = 1'b1
    } scal_state_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [31:0] mask;
    } scal_lease_t;

    typedef struct packed {
        logic        valid;
        logic        dhcp_en;
        logic [31:0] addr;
        logic [31:0] mask;
    } scal_nv_t;

endpackage

// ==== scal_srv_model.sv ====
// Purpose: far-side model, address server plus the unit's retained store
// Assumes: the server has already found this unit by its hardware address
// Notes:   store contents survive nrst, as flash survives a power cycle
module scal_srv_model (
    input  wire logic             core_clk,
    input  wire logic             dhcp_request,
    input  scal_pkg::scal_nv_t    nv_store,
    input  wire logic [31:0]      offer_addr,
    input  wire logic [7:0]       wait_cycles,
    output scal_pkg::scal_lease_t lease,
    output scal_pkg::scal_nv_t    nv_load
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt;

    initial begin
        cnt     = 8'h00;
        lease   = '0;
        nv_load = '0;
    end

    // Scan and pick by hardware address are done before a request is served
    always @(posedge core_clk) begin
        lease.valid <= 1'b0;
        lease.addr  <= ~lease.addr; // Idle bus inverts the last address every cycle
        if (nv_store.valid) begin
            nv_load <= nv_store;
        end
        // One answer per request; a lowered delay must not wait for the counter to wrap
        if (!dhcp_request || lease.valid) begin
            cnt <= 8'h00;
        end else if (cnt >= wait_cycles) begin
            cnt   <= 8'h00;
            lease <= '{valid: 1'b1, addr: offer_addr, mask: 32'hFFFFFF00};
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

// ==== tb_scal_loader.sv ====
// Purpose: self-checking bench of the switch configuration and address loader
// Assumes: each nrst pulse stands for one power cycle
// Notes:   server answer delay is varied between prompt and slow
module tb_scal_loader;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] OFFER = 32'h0A000042;
    localparam logic [31:0] OMASK = 32'hFFFFFF00;

    logic                  core_clk;
    logic                  nrst;
    logic [7:0]            first_switch_bank;
    logic [7:0]            second_switch_bank;
    logic                  hold_param_en;
    logic                  link_comm_error;
    logic                  master_idle;
    logic [31:0]           out_request;
    logic                  cmd_dhcp_enable;
    logic                  cmd_dhcp_disable;
    logic [7:0]            wait_cycles;
    scal_pkg::scal_lease_t lease;
    scal_pkg::scal_nv_t    nv_load;
    scal_pkg::scal_nv_t    nv_store;
    logic [31:0]           out_drive;
    logic [31:0]           ip_addr;
    logic [31:0]           net_mask;
    logic                  addr_valid;
    scal_pkg::scal_mode_t  addr_mode;
    logic                  dhcp_request;
    logic                  fault_active;
    int                    num_errors = 0;
    int                    checks = 0;
    int                    cycles = 0;

    scal_loader i_dut (.core_clk(core_clk), .nrst(nrst), .first_switch_bank(first_switch_bank),
        .second_switch_bank(second_switch_bank), .hold_param_en(hold_param_en),
        .link_comm_error(link_comm_error), .master_idle(master_idle),
        .out_request(out_request), .cmd_dhcp_enable(cmd_dhcp_enable),
        .cmd_dhcp_disable(cmd_dhcp_disable), .lease(lease), .nv_load(nv_load),
        .out_drive(out_drive), .ip_addr(ip_addr), .net_mask(net_mask),
        .addr_valid(addr_valid), .addr_mode(addr_mode), .dhcp_request(dhcp_request),
        .fault_active(fault_active), .nv_store(nv_store));

    scal_srv_model i_srv (.core_clk(core_clk), .dhcp_request(dhcp_request),
        .nv_store(nv_store), .offer_addr(OFFER), .wait_cycles(wait_cycles),
        .lease(lease), .nv_load(nv_load));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Only bit 0 of the first bank is ever set by the operator
    task automatic power_up(input logic [7:0] s1, input logic [7:0] s2);
        nrst               = 1'b0;
        first_switch_bank  = s1 & 8'h01;
        second_switch_bank = s2;
        step(20);
        nrst = 1'b1;
        step(2);
    endtask

    task automatic wait_lease();
        for (int i = 0; i < 60 && addr_valid !== 1'b1; i++) step(1);
    endtask

    task automatic pulse_cmd(input logic en, input logic dis);
        cmd_dhcp_enable  = en;
        cmd_dhcp_disable = dis;
        step(1);
        cmd_dhcp_enable  = 1'b0;
        cmd_dhcp_disable = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_static();
        logic [7:0] n [4] = '{8'h01, 8'h02, 8'hFD, 8'hFE};
        foreach (n[i]) begin
            power_up(8'h00, n[i]);
            second_switch_bank = ~n[i];
            pulse_cmd(1'b1, 1'b0);
            step(1);
            chk("ip", ip_addr, {24'h888102, n[i]});
            chk("mask", net_mask, 32'hFFFF0000);
            chk("mode", {30'h0, addr_mode}, 32'h0);
            chk("valid", {31'h0, addr_valid}, 32'h1);
            chk("req", {31'h0, dhcp_request}, 32'h0);
        end
    endtask

    task automatic t_dhcp();
        wait_cycles = 8'h20;
        power_up(8'h00, 8'hFF);
        chk("mode", {30'h0, addr_mode}, 32'h1);
        chk("req", {31'h0, dhcp_request}, 32'h1);
        wait_lease();
        chk("ip", ip_addr, OFFER);
        chk("req", {31'h0, dhcp_request}, 32'h0);
        chk("store", {31'h0, nv_store.valid}, 32'h0);
        step(2);
        chk("kept", {31'h0, nv_load.valid}, 32'h0);
        power_up(8'h00, 8'hFF);
        chk("valid", {31'h0, addr_valid}, 32'h0);
        chk("req", {31'h0, dhcp_request}, 32'h1);
    endtask

    task automatic t_remote();
        wait_cycles = 8'h03;
        power_up(8'h00, 8'h00);
        chk("mode", {30'h0, addr_mode}, 32'h2);
        chk("req", {31'h0, dhcp_request}, 32'h0);
        pulse_cmd(1'b1, 1'b0);
        chk("req", {31'h0, dhcp_request}, 32'h1);
        wait_lease();
        chk("mask", net_mask, OMASK);
        chk("store", {30'h0, nv_store.valid, nv_store.dhcp_en}, 32'h3);
        step(2);
        power_up(8'h00, 8'h00);
        chk("req", {31'h0, dhcp_request}, 32'h1);
        wait_cycles = 8'h00;
        wait_lease();
        pulse_cmd(1'b1, 1'b1);
        chk("req", {31'h0, dhcp_request}, 32'h0);
        chk("store", {30'h0, nv_store.valid, nv_store.dhcp_en}, 32'h2);
        step(2);
        power_up(8'h00, 8'h00);
        chk("valid", {31'h0, addr_valid}, 32'h1);
        chk("ip", ip_addr, OFFER);
        chk("req", {31'h0, dhcp_request}, 32'h0);
    endtask

    task automatic t_fault(input logic [7:0] s1, input logic param, input logic hold);
        power_up(s1, 8'h01);
        hold_param_en = param;
        out_request   = 32'hA5C30F81;
        step(2);
        chk("out", out_drive, 32'hA5C30F81);
        link_comm_error = 1'b1;
        out_request     = 32'h5A3CF07E;
        step(1);
        chk("out", out_drive, hold ? 32'hA5C30F81 : 32'h0);
        chk("fault", {31'h0, fault_active}, 32'h1);
        link_comm_error = 1'b0;
        step(2);
        chk("out", out_drive, 32'h5A3CF07E);
        master_idle = 1'b1;
        out_request = 32'h00000001;
        step(1);
        chk("out", out_drive, hold ? 32'h5A3CF07E : 32'h0);
        master_idle = 1'b0;
    endtask

    initial begin
        nrst               = 1'b0;
        first_switch_bank  = 8'h00;
        second_switch_bank = 8'h00;
        hold_param_en      = 1'b0;
        link_comm_error    = 1'b0;
        master_idle        = 1'b0;
        out_request        = 32'h0;
        cmd_dhcp_enable    = 1'b0;
        cmd_dhcp_disable   = 1'b0;
        wait_cycles        = 8'h02;
        t_static();
        t_dhcp();
        t_remote();
        t_fault(8'h01, 1'b1, 1'b1);
        t_fault(8'h01, 1'b0, 1'b0);
        t_fault(8'h00, 1'b1, 1'b0);
        final_report();
    end
endmodule
